//--- hdl/cmd_comparator_ctrl.sv
// digital control around one analog comparator: modes, pin roles, polarity,
// timer-clock synchronisation, change detection and the change interrupt.
// assumes an apb master on I_CLOCK, an asynchronous raw comparator level and
// a timer clock source that is sampled, not used as a clock.
`timescale 1ns/100ps
`default_nettype none
`include "cmd_params.svh"

// Functional notes
// - raw result high when positive input higher
// - three-bit field picks one of eight modes
// - mode 000: off, both inputs analog
// - mode 111: off, only negative input analog
// - modes 011-110 use internal reference voltage
// - result drives pin only in 001/011/101
// - analog pins get input buffer disabled
// - analog pins read zero on port reads
// - invert bit flips result before bit and pin
// - result bit readable in every mode
// - modes 101/110: switch bit picks inverting input
// - sync latches result on timer clock fall
// - sleep holds first-phase latch open
// - control read captures reference latch
// - first-phase latch xor reference forms mismatch
// - flag held set while mismatch persists
// - control write also refreshes reference latch
// - flag cleared by writing zero, set by one
// - irq needs all three enables; flag sets regardless
// - flag cannot clear during persisting mismatch
// - reset returns registers to mode 000
// - aux sync bit enables timer-clock latching
// - gate select clear routes result to timer gate
// - control bits: result 6, invert 4, switch 3, mode 2:0
module cmd_comparator_ctrl
(
  input  wire logic                       I_CLOCK,
  input  wire logic                       I_SYS_RST,
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [`CMD_ADDR_W-1:0]     I_PADDR,
  input  wire logic [31:0]                I_PWDATA,
  input  wire logic [3:0]                 I_PSTRB,
  output logic      [31:0]                O_PRDATA,
  output logic                            O_PREADY,
  output logic                            O_PSLVERR,
  input  wire logic                       I_RAW_RESULT,
  input  wire logic                       I_TIMER_CLK,
  input  wire logic                       I_PHASE_ONE_TICK,
  input  wire logic                       I_SLEEP,
  input  wire logic [`CMD_NUM_PINS-1:0]   I_PIN_LEVEL,
  input  wire logic [`CMD_NUM_PINS-1:0]   I_PIN_DIRECTION_BIT,
  output logic      [`CMD_NUM_PINS-1:0]   O_PORT_READ,
  output logic      [`CMD_NUM_PINS-1:0]   O_INBUF_DISABLE,
  output logic                            O_RESULT_PIN_O,
  output logic                            O_RESULT_PIN_OE,
  output logic                            O_COMP_ENABLE,
  output logic                            O_REF_INTERNAL,
  output logic                            O_NEG_FROM_POS_PIN,
  output logic                            O_COMP_RESULT,
  output logic                            O_TIMER_GATE_FROM_COMP,
  output logic                            O_IRQ
);
  import cmd_pkg::*;

  // pin roles and comparator state for each mode
  function automatic cmd_cfg_t mode_decode(input cmd_mode_t mode);
    cmd_cfg_t cfg;
    cfg = '0;
    case (mode)
      CMD_MODE_RESET:   cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 3'h3};
      CMD_MODE_OUT:     cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 3'h3};
      CMD_MODE_NO_OUT:  cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h3};
      CMD_MODE_REF_OUT: cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 3'h1};
      CMD_MODE_REF:     cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 3'h1};
      CMD_MODE_MUX_OUT: cfg = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h3};
      CMD_MODE_MUX:     cfg = '{1'b1, 1'b1, 1'b0, 1'b1, 3'h3};
      CMD_MODE_OFF:     cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 3'h1};
      default:          cfg = '0;
    endcase
    return cfg;
  endfunction : mode_decode

  localparam int SYNC_W = `CMD_NUM_PINS + 2;

  // control state
  cmd_mode_t                   mode_ff;
  logic                        inv_ff;
  logic                        switch_ff;
  logic                        gate_sel_ff;
  logic                        sync_en_ff;
  logic                        flag_ff;
  logic                        irq_en_ff;
  logic                        global_en_ff;
  logic                        periph_en_ff;

  // input conditioning
  logic [SYNC_W-1:0]           sync1_ff;
  logic [SYNC_W-1:0]           sync2_ff;
  logic [SYNC_W-1:0]           sync3_ff;
  logic [SYNC_W-1:0]           lvl_ff;
  logic [SYNC_W-1:0]           nxt_lvl;

  // result path and mismatch latches
  logic                        sync_latch_ff;
  logic                        tick_latch_ff;
  logic                        ref_latch_ff;
  logic                        result_out_ff;
  logic                        timer_fall;
  logic                        polar;
  logic                        result;
  logic                        mismatch;
  cmd_cfg_t                    cfg;

  // bus decode
  logic                        setup;
  logic                        access;
  logic                        wr;
  logic                        addr_hit;
  logic                        ctrl_access;
  logic [31:0]                 nxt_rdata;
  logic [`CMD_NUM_PINS-1:0]    port_val;

  assign cfg = mode_decode(mode_ff);

  // raw result, timer clock and pads are asynchronous: three stages each,
  // a level change counts once the second and third stage agree
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      lvl_ff   <= '0;
    end
    else
    begin
      sync1_ff <= {I_PIN_LEVEL, I_TIMER_CLK, I_RAW_RESULT};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff   <= nxt_lvl;
    end
  end

  always_comb
  begin
    for (int i = 0; i < SYNC_W; i++)
    begin
      nxt_lvl[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : lvl_ff[i];
    end
  end

  assign timer_fall = lvl_ff[1] && !nxt_lvl[1];

  // off modes force zero ahead of the inverter so the bit reads the invert bit
  assign polar  = (cfg.on & lvl_ff[0]) ^ inv_ff;
  assign result = sync_en_ff ? sync_latch_ff : polar;

  // latch on the falling edge so the timer, counting on the rising edge,
  // never sees the gate move under an increment
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      sync_latch_ff <= 1'b0;
    else if (timer_fall)
      sync_latch_ff <= polar;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      tick_latch_ff <= 1'b0;
    else if (I_PHASE_ONE_TICK || I_SLEEP)
      tick_latch_ff <= result;
  end

  assign setup       = I_PSEL && !I_PENABLE;
  assign access      = I_PSEL && I_PENABLE;
  assign wr          = access && I_PWRITE && I_PSTRB[0];
  assign ctrl_access = access && (I_PADDR == `CMD_OFF_CTRL);

  // any access to the control register, write included, refreshes the reference
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      ref_latch_ff <= 1'b0;
    else if (ctrl_access)
      ref_latch_ff <= result;
  end

  assign mismatch = ref_latch_ff ^ tick_latch_ff;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      mode_ff   <= cmd_mode_t'(3'(`CMD_CTRL_RESET));
      inv_ff    <= 1'b0;
      switch_ff <= 1'b0;
    end
    else if (wr && I_PADDR == `CMD_OFF_CTRL)
    begin
      mode_ff   <= cmd_mode_t'(I_PWDATA[`CMD_CTRL_MODE_MSB:0]);
      inv_ff    <= I_PWDATA[`CMD_CTRL_INV_BIT];
      switch_ff <= I_PWDATA[`CMD_CTRL_SWITCH_BIT];
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      gate_sel_ff <= 1'(`CMD_AUX_RESET >> `CMD_AUX_GATE_SEL_BIT);
      sync_en_ff  <= 1'b0;
    end
    else if (wr && I_PADDR == `CMD_OFF_AUX)
    begin
      gate_sel_ff <= I_PWDATA[`CMD_AUX_GATE_SEL_BIT];
      sync_en_ff  <= I_PWDATA[`CMD_AUX_SYNC_BIT];
    end
  end

  // a standing mismatch wins over a software clear
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      flag_ff <= 1'b0;
    else if (mismatch)
      flag_ff <= 1'b1;
    else if (wr && I_PADDR == `CMD_OFF_FLAG)
      flag_ff <= I_PWDATA[`CMD_FLAG_BIT];
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      irq_en_ff    <= 1'b0;
      global_en_ff <= 1'b0;
      periph_en_ff <= 1'b0;
    end
    else
    begin
      if (wr && I_PADDR == `CMD_OFF_IRQ_EN)
        irq_en_ff <= I_PWDATA[`CMD_IRQ_EN_BIT];
      if (wr && I_PADDR == `CMD_OFF_IRQ_CTRL)
      begin
        global_en_ff <= I_PWDATA[`CMD_GLOBAL_EN_BIT];
        periph_en_ff <= I_PWDATA[`CMD_PERIPH_EN_BIT];
      end
    end
  end

  assign O_IRQ = flag_ff && irq_en_ff && periph_en_ff && global_en_ff;

  // pin roles
  assign O_INBUF_DISABLE    = cfg.analog;
  assign port_val           = lvl_ff[SYNC_W-1:2] & ~cfg.analog;
  assign O_PORT_READ        = port_val;
  assign O_COMP_ENABLE      = cfg.on;
  assign O_REF_INTERNAL     = cfg.int_ref;
  assign O_NEG_FROM_POS_PIN = cfg.mux && switch_ff;
  // the driver follows the direction bit that software sets for the pin
  assign O_RESULT_PIN_OE    = cfg.drive && !I_PIN_DIRECTION_BIT[`CMD_PIN_RESULT];
  assign O_RESULT_PIN_O     = result_out_ff;
  assign O_COMP_RESULT      = result_out_ff;
  assign O_TIMER_GATE_FROM_COMP = !gate_sel_ff;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      result_out_ff <= 1'b0;
    else
      result_out_ff <= result;
  end

  // read data is prepared in the setup cycle, so every access ends in one cycle
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    addr_hit  = 1'b1;
    case (I_PADDR)
      `CMD_OFF_CTRL:
      begin
        nxt_rdata[`CMD_CTRL_RESULT_BIT]   = result;
        nxt_rdata[`CMD_CTRL_INV_BIT]      = inv_ff;
        nxt_rdata[`CMD_CTRL_SWITCH_BIT]   = switch_ff;
        nxt_rdata[`CMD_CTRL_MODE_MSB:0]   = mode_ff;
      end
      `CMD_OFF_AUX:
      begin
        nxt_rdata[`CMD_AUX_GATE_SEL_BIT]  = gate_sel_ff;
        nxt_rdata[`CMD_AUX_SYNC_BIT]      = sync_en_ff;
      end
      `CMD_OFF_FLAG:     nxt_rdata[`CMD_FLAG_BIT]   = flag_ff;
      `CMD_OFF_IRQ_EN:   nxt_rdata[`CMD_IRQ_EN_BIT] = irq_en_ff;
      `CMD_OFF_IRQ_CTRL:
      begin
        nxt_rdata[`CMD_GLOBAL_EN_BIT]     = global_en_ff;
        nxt_rdata[`CMD_PERIPH_EN_BIT]     = periph_en_ff;
      end
      `CMD_OFF_PORT:     nxt_rdata[`CMD_NUM_PINS-1:0] = port_val;
      default:           addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      O_PRDATA <= 32'h0000_0000;
    else if (setup && !I_PWRITE)
      O_PRDATA <= nxt_rdata;
  end

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access && !addr_hit;

  // checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  logic past_valid_ff;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      past_valid_ff <= 1'b0;
    else
      past_valid_ff <= 1'b1;
  end

  a_off_result_inv: assert property (!cfg.on && !sync_en_ff |-> result == inv_ff)
    else $error("off comparator result not equal to invert bit");

  a_invert_path: assert property (cfg.on && !sync_en_ff |-> result == (lvl_ff[0] ^ inv_ff))
    else $error("result does not follow raw level and invert bit");

  a_pin_drive_modes: assert property (O_RESULT_PIN_OE |-> mode_ff inside {CMD_MODE_OUT, CMD_MODE_REF_OUT, CMD_MODE_MUX_OUT})
    else $error("result pin driven outside output modes");

  a_analog_reads_zero: assert property ((O_PORT_READ & O_INBUF_DISABLE) == 3'h0)
    else $error("analog pin read non-zero");

  a_ref_on_access: assert property (ctrl_access |=> ref_latch_ff == $past(result))
    else $error("reference latch not captured on control access");

  a_flag_holds: assert property (mismatch |=> flag_ff)
    else $error("flag not set while mismatch stands");

  a_flag_sw_write: assert property (wr && I_PADDR == `CMD_OFF_FLAG && !mismatch |=> flag_ff == $past(I_PWDATA[`CMD_FLAG_BIT]))
    else $error("flag write not honoured");

  a_irq_gating: assert property (O_IRQ == (flag_ff && irq_en_ff && periph_en_ff && global_en_ff))
    else $error("interrupt does not match enables");

  a_sync_hold: assert property (sync_en_ff && !timer_fall ##1 sync_en_ff |-> $stable(result))
    else $error("synchronised result moved without timer clock fall");

  a_reset_mode: assert property (!past_valid_ff |-> mode_ff == CMD_MODE_RESET && gate_sel_ff && !flag_ff)
    else $error("mode not in reset configuration after reset");

  a_mux_switch: assert property (O_NEG_FROM_POS_PIN |-> cfg.mux && switch_ff && O_INBUF_DISABLE[`CMD_PIN_POS])
    else $error("input switch active outside multiplexed modes");

  a_result_bit_read: assert property (setup && !I_PWRITE && I_PADDR == `CMD_OFF_CTRL |=> O_PRDATA[`CMD_CTRL_RESULT_BIT] == $past(result))
    else $error("result bit read back wrong");

  c_flag_from_change: cover property (!flag_ff ##1 mismatch ##1 flag_ff);
  c_flag_sw_set: cover property (wr && I_PADDR == `CMD_OFF_FLAG && I_PWDATA[`CMD_FLAG_BIT] ##1 flag_ff);
  c_mux_switched: cover property (O_NEG_FROM_POS_PIN && O_RESULT_PIN_OE);
  c_sync_edge: cover property (sync_en_ff && timer_fall);

endmodule : cmd_comparator_ctrl
`default_nettype wire

//--- inc/cmd_params.svh
// register map, field positions and reset values of the comparator control block
// assumes an apb slave with 32-bit data; each register takes one aligned word
`ifndef CMD_PARAMS_SVH
`define CMD_PARAMS_SVH

`define CMD_ADDR_W            8
`define CMD_OFF_CTRL          8'h00
`define CMD_OFF_AUX           8'h04
`define CMD_OFF_FLAG          8'h08
`define CMD_OFF_IRQ_EN        8'h0c
`define CMD_OFF_IRQ_CTRL      8'h10
`define CMD_OFF_PORT          8'h14

`define CMD_CTRL_RESULT_BIT   6
`define CMD_CTRL_INV_BIT      4
`define CMD_CTRL_SWITCH_BIT   3
`define CMD_CTRL_MODE_MSB     2
`define CMD_AUX_GATE_SEL_BIT  1
`define CMD_AUX_SYNC_BIT      0
`define CMD_FLAG_BIT          3
`define CMD_IRQ_EN_BIT        3
`define CMD_GLOBAL_EN_BIT     7
`define CMD_PERIPH_EN_BIT     6

`define CMD_CTRL_RESET        8'h00
`define CMD_AUX_RESET         2'h2
`define CMD_NUM_PINS          3
`define CMD_PIN_NEG           0
`define CMD_PIN_POS           1
`define CMD_PIN_RESULT        2

`endif

//--- inc/cmd_pkg.sv
// types shared by the comparator control block
// assumes cmd_params.svh for all numeric constants
package cmd_pkg;

  typedef enum logic [2:0]
  {
    CMD_MODE_RESET      = 3'b000,
    CMD_MODE_OUT        = 3'b001,
    CMD_MODE_NO_OUT     = 3'b010,
    CMD_MODE_REF_OUT    = 3'b011,
    CMD_MODE_REF        = 3'b100,
    CMD_MODE_MUX_OUT    = 3'b101,
    CMD_MODE_MUX        = 3'b110,
    CMD_MODE_OFF        = 3'b111
  } cmd_mode_t;

  typedef struct packed
  {
    logic       on;
    logic       int_ref;
    logic       drive;
    logic       mux;
    logic [2:0] analog;
  } cmd_cfg_t;

endpackage : cmd_pkg

//--- verif/cmd_analog_model.sv
// behavioural comparator core, phase-one tick and timer clock source
// assumes the bench sets both input voltages as plain codes on one clock
`timescale 1ns/100ps
`default_nettype none
module cmd_analog_model
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_vpos,
  input  wire logic [7:0] i_vneg,
  output logic            o_raw,
  output logic            o_tick,
  output logic            o_timer_clk
);
  logic [5:0] cnt_ff = 6'h00;

  // no hysteresis: equal inputs count as low
  assign o_raw = (i_vpos > i_vneg);

  always @(posedge i_clk)
  begin
    cnt_ff <= cnt_ff + 6'h01;
  end

  // one tick in four cycles, timer clock half period of 32 cycles
  assign o_tick      = (cnt_ff[1:0] == 2'h0);
  assign o_timer_clk = cnt_ff[5];
endmodule : cmd_analog_model
`default_nettype wire

//--- verif/cmd_comparator_ctrl_test.sv
// self-checking bench for the comparator control block
// assumes the analog model beside it and a zero-wait apb slave
`timescale 1ns/100ps
`default_nettype none
`include "cmd_params.svh"
module cmd_comparator_ctrl_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  vpos = 8'h10;
  logic [7:0]  vneg = 8'h20;
  logic [2:0]  dir = 3'b011;
  logic        sleep = 1'b0;
  logic        tick_en = 1'b1;
  logic        raw;
  logic        tick;
  logic        tclk;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  port_rd;
  logic [2:0]  inbuf;
  logic        res_o;
  logic        res_oe;
  logic        comp_en;
  logic        ref_int;
  logic        neg_sw;
  logic        res;
  logic        gate;
  logic        irq;
  int          fail_count = 0;
  int          check_count = 0;
  logic [2:0]  ab [8] = '{3'b011, 3'b011, 3'b011, 3'b001, 3'b001, 3'b011, 3'b011, 3'b001};

  initial
  begin
    forever #4 clk = ~clk;
  end

  cmd_analog_model model
  (
    .i_clk       (clk),
    .i_vpos      (vpos),
    .i_vneg      (vneg),
    .o_raw       (raw),
    .o_tick      (tick),
    .o_timer_clk (tclk)
  );

  cmd_comparator_ctrl DUT
  (
    .I_CLOCK                (clk),
    .I_SYS_RST              (rst),
    .I_PSEL                 (psel),
    .I_PENABLE              (penable),
    .I_PWRITE               (pwrite),
    .I_PADDR                (paddr),
    .I_PWDATA               (pwdata),
    .I_PSTRB                (4'hf),
    .O_PRDATA               (prdata),
    .O_PREADY               (pready),
    .O_PSLVERR              (pslverr),
    .I_RAW_RESULT           (raw),
    .I_TIMER_CLK            (tclk),
    .I_PHASE_ONE_TICK       (tick && tick_en),
    .I_SLEEP                (sleep),
    .I_PIN_LEVEL            (3'b111),
    .I_PIN_DIRECTION_BIT    (dir),
    .O_PORT_READ            (port_rd),
    .O_INBUF_DISABLE        (inbuf),
    .O_RESULT_PIN_O         (res_o),
    .O_RESULT_PIN_OE        (res_oe),
    .O_COMP_ENABLE          (comp_en),
    .O_REF_INTERNAL         (ref_int),
    .O_NEG_FROM_POS_PIN     (neg_sw),
    .O_COMP_RESULT          (res),
    .O_TIMER_GATE_FROM_COMP (gate),
    .O_IRQ                  (irq)
  );

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q       = prdata;
    e       = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd

  task automatic setv(input logic [7:0] p, input logic [7:0] n);
    @(posedge clk);
    vpos <= p;
    vneg <= n;
  endtask : setv

  initial
  begin
    logic [31:0] q;
    logic        e;
    tk(20);
    rst <= 1'b0;
    tk(2);
    rd(`CMD_OFF_CTRL, 32'h00);
    rd(`CMD_OFF_AUX, 32'h02);
    chk(32'(inbuf), 32'h3);
    chk(32'(comp_en), 32'h0);
    chk(32'(gate), 32'h0);
    for (int m = 0; m < 8; m++)
    begin
      wr(`CMD_OFF_CTRL, 32'(m));
      tk(8);
      chk(32'(neg_sw), 32'h0);
      wr(`CMD_OFF_CTRL, 32'(m | 8));
      tk(8);
      chk(32'(inbuf), 32'(ab[m]));
      chk(32'(port_rd), 32'(3'b111 & ~ab[m]));
      chk(32'(res_oe), 32'(m == 1 || m == 3 || m == 5));
      chk(32'(comp_en), 32'(m != 0 && m != 7));
      chk(32'(ref_int), 32'(m >= 3 && m <= 6));
      chk(32'(neg_sw), 32'(m == 5 || m == 6));
      rd(`CMD_OFF_CTRL, 32'(m | 8));
    end
    setv(8'hc8, 8'h64);
    wr(`CMD_OFF_CTRL, 32'h01);
    tk(12);
    rd(`CMD_OFF_CTRL, 32'h41);
    chk(32'(res), 32'h1);
    chk(32'(res_o), 32'h1);
    dir <= 3'b111;
    tk(2);
    chk(32'(res_oe), 32'h0);
    dir <= 3'b011;
    wr(`CMD_OFF_CTRL, 32'h11);
    tk(12);
    rd(`CMD_OFF_CTRL, 32'h11);
    chk(32'(res_o), 32'h0);
    wr(`CMD_OFF_CTRL, 32'h10);
    tk(12);
    rd(`CMD_OFF_CTRL, 32'h50);
    wr(`CMD_OFF_CTRL, 32'h07);
    tk(12);
    rd(`CMD_OFF_CTRL, 32'h07);
    // change detection with every enable set
    wr(`CMD_OFF_CTRL, 32'h02);
    wr(`CMD_OFF_IRQ_EN, 32'h08);
    wr(`CMD_OFF_IRQ_CTRL, 32'hc0);
    tk(12);
    rd(`CMD_OFF_CTRL, 32'h42);
    wr(`CMD_OFF_FLAG, 32'h00);
    tk(16);
    rd(`CMD_OFF_FLAG, 32'h00);
    setv(8'h64, 8'hc8);
    tk(16);
    rd(`CMD_OFF_FLAG, 32'h08);
    chk(32'(irq), 32'h1);
    wr(`CMD_OFF_FLAG, 32'h00);
    rd(`CMD_OFF_FLAG, 32'h08);
    rd(`CMD_OFF_CTRL, 32'h02);
    wr(`CMD_OFF_FLAG, 32'h00);
    rd(`CMD_OFF_FLAG, 32'h00);
    chk(32'(irq), 32'h0);
    setv(8'hc8, 8'h64);
    tk(16);
    rd(`CMD_OFF_FLAG, 32'h08);
    wr(`CMD_OFF_CTRL, 32'h02);
    wr(`CMD_OFF_FLAG, 32'h00);
    rd(`CMD_OFF_FLAG, 32'h00);
    wr(`CMD_OFF_FLAG, 32'h08);
    rd(`CMD_OFF_FLAG, 32'h08);
    wr(`CMD_OFF_IRQ_CTRL, 32'h40);
    tk(2);
    chk(32'(irq), 32'h0);
    wr(`CMD_OFF_FLAG, 32'h00);
    // ticks masked: only sleep lets the change latch follow the result
    tick_en <= 1'b0;
    setv(8'h64, 8'hc8);
    tk(16);
    rd(`CMD_OFF_FLAG, 32'h00);
    sleep <= 1'b1;
    tk(4);
    rd(`CMD_OFF_FLAG, 32'h08);
    sleep <= 1'b0;
    tick_en <= 1'b1;
    rd(`CMD_OFF_CTRL, 32'h02);
    wr(`CMD_OFF_FLAG, 32'h00);
    setv(8'hc8, 8'h64);
    // gate routing and timer-clock synchronisation
    wr(`CMD_OFF_AUX, 32'h00);
    tk(2);
    chk(32'(gate), 32'h1);
    wr(`CMD_OFF_CTRL, 32'h01);
    wr(`CMD_OFF_AUX, 32'h01);
    @(negedge tclk);
    tk(8);
    setv(8'h64, 8'hc8);
    tk(12);
    chk(32'(res), 32'h1);
    @(negedge tclk);
    tk(12);
    chk(32'(res), 32'h0);
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    chk(32'(pready), 32'h1);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : cmd_comparator_ctrl_test
`default_nettype wire
